// ### rtl/adc_ctl_regs.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH
`define OFS_STATUS     8'h00
`define OFS_MODE       8'h04
`define OFS_CONFIG     8'h08
`define OFS_IRQ_MASK   8'h0c
`define OFS_CUR_RES    8'h10
`define OFS_VOLT_RES   8'h14
`define OFS_TEMP_RES   8'h18
`define OFS_FILTER     8'h1c
`define OFS_THRESHOLD  8'h20
`define OFS_TCOUNT     8'h24
`define OFS_ACCUM      8'h28
`define OFS_CTRL       8'h2c
`define CFG_GND_EN     7
`define CFG_OVR_EN     2
`define CFG_CMP_EN     3
`define CFG_ACC_EN     4
`define CFG_CNT_EN     5
`define MDE_GND_RES    6
`define MDE_CUR_EN     0
`define MDE_VT_EN      1
`define MDE_CAL        2
`define MDE_CHOP       3
`define MDE_LOWPWR     4
`define MDE_VSEL       9:8
`define ST_CUR_RDY     0
`define ST_VOLT_RDY    1
`define ST_TEMP_RDY    2
`define ST_OVR         3
`define ST_THR         4
`define ST_CNT         5
`define ST_CAL_DONE    15
`define RST_FILTER     16'h0007
`define RST_ZERO       16'h0000
`define CLK_HZ         100000000
`define OVR_PERIOD_US  125
`define OVR_CYCLES     ((`CLK_HZ / 1000000) * `OVR_PERIOD_US)
`define RATE_BASE_HZ   8000
`define RATE_DIV_BASE  (`CLK_HZ / `RATE_BASE_HZ)
`define SETTLE_NOCHOP  2'd3
`define SETTLE_CHOP    2'd2
`endif

// ### rtl/adc_ctl_pkg.sv
// types shared by the converter control
package adc_ctl_pkg;
  typedef enum logic [1:0] {
    SRC_BATTERY  = 2'b00,
    SRC_EXT_TEMP = 2'b01,
    SRC_CHIP_TMP = 2'b11
  } vt_source_type;
  typedef enum logic [1:0] {
    SET_IDLE   = 2'b00,
    SET_SETTLE = 2'b01,
    SET_VALID  = 2'b11
  } settle_state_type;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic        range_err;
  } conv_result_type;
endpackage

// ### rtl/settle_gate.sv
// counts conversion cycles after a restart and passes only settled results
`timescale 1ns/1ns
`default_nettype none
module settle_gate (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        restart,
  input  wire logic [1:0]  need,
  input  wire logic        conv_in,
  output logic             conv_ok
);
  adc_ctl_pkg::settle_state_type state_ff;
  adc_ctl_pkg::settle_state_type nxt_state;
  logic [1:0]                    cnt_ff;
  logic [1:0]                    nxt_cnt;
  wire                           last_cycle = (cnt_ff + 2'd1 >= need);

  // leave idle on the first cycle after reset, then discard conversions until the count is met
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      adc_ctl_pkg::SET_IDLE: begin
        nxt_state = adc_ctl_pkg::SET_SETTLE;
        nxt_cnt   = 2'd0;
      end
      adc_ctl_pkg::SET_SETTLE: begin
        if (conv_in) begin
          nxt_cnt = cnt_ff + 2'd1;
          if (last_cycle) begin
            nxt_state = adc_ctl_pkg::SET_VALID;
          end
        end
      end
      adc_ctl_pkg::SET_VALID: begin
        nxt_state = adc_ctl_pkg::SET_VALID;
      end
      default: begin
        nxt_state = adc_ctl_pkg::SET_IDLE;
      end
    endcase
    if (restart) begin
      nxt_state = adc_ctl_pkg::SET_SETTLE;
      nxt_cnt   = 2'd0;
    end
  end

  // the settling conversion itself counts as the first valid one
  assign conv_ok = conv_in && !restart &&
                   ((state_ff == adc_ctl_pkg::SET_VALID) ||
                    (state_ff == adc_ctl_pkg::SET_SETTLE && last_cycle));

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_ff <= adc_ctl_pkg::SET_IDLE;
      cnt_ff   <= 2'd0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end
endmodule
`default_nettype wire

// ### rtl/adc_ctl.sv
// digital control around the current and voltage/temperature converters
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctl_regs.svh"
module adc_ctl (
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [31:0]                        reg_rdata,
  input  wire logic                          mod_cur_tick,
  input  wire logic [15:0]                   mod_cur_data,
  input  wire logic                          mod_cur_err,
  input  wire logic                          mod_vt_tick,
  input  wire logic [15:0]                   mod_vt_data,
  input  wire logic                          mod_vt_err,
  input  wire logic                          cur_overrange,
  input  wire logic                          cal_done,
  input  wire logic                          core_powered_down,
  output logic                               conv_tick,
  output logic [1:0]                         vt_mux_sel,
  output logic                               atten_buf_en,
  output logic                               ground_switch_pin_o,
  output logic                               ground_switch_pin_oe,
  output logic                               ground_switch_res_sel,
  output logic                               converter_irq
);
  adc_ctl_pkg::reg_req_type     req;
  adc_ctl_pkg::conv_result_type cur_res;
  adc_ctl_pkg::conv_result_type vt_res;
  logic [15:0] converter_status_reg_ff;
  logic [15:0] nxt_status;
  logic [15:0] converter_mode_reg_ff;
  logic [7:0]  converter_config_reg_ff;
  logic [7:0]  converter_irq_mask_reg_ff;
  logic [15:0] current_result_reg_ff;
  logic [15:0] voltage_result_reg_ff;
  logic [15:0] temp_result_reg_ff;
  logic [15:0] filter_rate_reg_ff;
  logic [15:0] current_threshold_reg_ff;
  logic [15:0] threshold_count_limit_reg_ff;
  logic [31:0] accum_ff;
  logic [15:0] conv_count_ff;
  logic [31:0] rate_cnt_ff;
  logic [15:0] ovr_cnt_ff;
  logic [31:0] reg_rdata_ff;
  logic [1:0]  vsel_prev_ff;

  // magnitude of a signed 16-bit result, used by the comparator
  function automatic logic [15:0] mag16(input logic [15:0] v);
    mag16 = v[15] ? (~v + 16'h0001) : v;
  endfunction

  // bus request bundle and address decode
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  wire wr_mode   = req.wr && (req.addr == `OFS_MODE);
  wire wr_config = req.wr && (req.addr == `OFS_CONFIG);
  wire wr_mask   = req.wr && (req.addr == `OFS_IRQ_MASK);
  wire wr_filter = req.wr && (req.addr == `OFS_FILTER);
  wire wr_thr    = req.wr && (req.addr == `OFS_THRESHOLD);
  wire wr_tcnt   = req.wr && (req.addr == `OFS_TCOUNT);
  wire wr_acc    = req.wr && (req.addr == `OFS_ACCUM);
  wire rd_cur    = req.rd && (req.addr == `OFS_CUR_RES);
  wire rd_volt   = req.rd && (req.addr == `OFS_VOLT_RES);
  wire rd_temp   = req.rd && (req.addr == `OFS_TEMP_RES);

  // mode and configuration fields
  wire cur_en    = converter_mode_reg_ff[`MDE_CUR_EN];
  wire vt_en     = converter_mode_reg_ff[`MDE_VT_EN];
  wire chop_on   = converter_mode_reg_ff[`MDE_CHOP];
  wire low_power = converter_mode_reg_ff[`MDE_LOWPWR];
  wire gnd_res   = converter_mode_reg_ff[`MDE_GND_RES];
  wire gnd_en    = converter_config_reg_ff[`CFG_GND_EN];
  wire ovr_en    = converter_config_reg_ff[`CFG_OVR_EN];
  wire cmp_en    = converter_config_reg_ff[`CFG_CMP_EN];
  wire acc_en    = converter_config_reg_ff[`CFG_ACC_EN];
  wire cnt_en    = converter_config_reg_ff[`CFG_CNT_EN];

  // three legal sources; the unused code falls back to the battery
  wire [1:0] vsel_raw = converter_mode_reg_ff[`MDE_VSEL];
  assign vt_mux_sel = (vsel_raw == 2'b10) ? adc_ctl_pkg::SRC_BATTERY : vsel_raw;
  assign atten_buf_en = vt_en && (vt_mux_sel == adc_ctl_pkg::SRC_BATTERY);

  // ground switch: float unless enabled, then direct or via resistor
  assign ground_switch_pin_oe  = gnd_en;
  assign ground_switch_pin_o   = 1'b0;
  assign ground_switch_res_sel = gnd_en && gnd_res;

  // conversion rate: period = base * (filter + 1), four times longer in low power
  wire [31:0] rate_div = (32'(`RATE_DIV_BASE) * (32'(filter_rate_reg_ff[10:0]) + 32'd1))
                         << (low_power ? 2 : 0);
  assign conv_tick = (rate_cnt_ff + 32'd1 >= rate_div);

  always_ff @(posedge core_clk) begin
    if (!rst_b || wr_filter || wr_mode || conv_tick) begin
      rate_cnt_ff <= 32'd0;
    end else begin
      rate_cnt_ff <= rate_cnt_ff + 32'd1;
    end
  end

  // settling gates: restart on enable change, channel switch or mode write
  logic cur_ok;
  logic vt_ok;
  wire vsel_change = (vt_mux_sel != vsel_prev_ff);
  settle_gate u_cur_settle (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .restart  (wr_mode),
    .need     (chop_on ? `SETTLE_CHOP : `SETTLE_NOCHOP),
    .conv_in  (mod_cur_tick && cur_en),
    .conv_ok  (cur_ok)
  );
  settle_gate u_vt_settle (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .restart  (wr_mode || vsel_change),
    .need     (chop_on ? `SETTLE_CHOP : `SETTLE_NOCHOP),
    .conv_in  (mod_vt_tick && vt_en),
    .conv_ok  (vt_ok)
  );
  assign cur_res = '{valid: cur_ok, data: mod_cur_data, range_err: mod_cur_err};
  assign vt_res  = '{valid: vt_ok, data: mod_vt_data, range_err: mod_vt_err};

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      vsel_prev_ff <= 2'b00;
    end else begin
      vsel_prev_ff <= vt_mux_sel;
    end
  end

  // ready-flag clearing and result write permission
  wire clr_ready = rd_cur || (!cur_en && (rd_volt || rd_temp));
  wire is_temp   = (vt_mux_sel != adc_ctl_pkg::SRC_BATTERY);
  wire cur_wr_ok = core_powered_down || !converter_status_reg_ff[`ST_CUR_RDY];
  wire vt_rdy    = is_temp ? converter_status_reg_ff[`ST_TEMP_RDY]
                           : converter_status_reg_ff[`ST_VOLT_RDY];
  wire vt_wr_ok  = core_powered_down || !vt_rdy;
  wire cur_store = cur_res.valid && cur_wr_ok;
  wire vt_store  = vt_res.valid && vt_wr_ok;

  // result registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      current_result_reg_ff <= `RST_ZERO;
      voltage_result_reg_ff <= `RST_ZERO;
      temp_result_reg_ff    <= `RST_ZERO;
    end else begin
      if (cur_store) begin
        current_result_reg_ff <= cur_res.data;
      end
      if (vt_store && !is_temp) begin
        voltage_result_reg_ff <= vt_res.data;
      end
      if (vt_store && is_temp) begin
        temp_result_reg_ff <= vt_res.data;
      end
    end
  end

  // accumulator sums sign-extended current results
  always_ff @(posedge core_clk) begin
    if (!rst_b || wr_acc) begin
      accum_ff <= 32'h0000_0000;
    end else if (acc_en && cur_res.valid) begin
      accum_ff <= accum_ff + {{16{cur_res.data[15]}}, cur_res.data};
    end
  end

  // conversion counter and threshold compare
  wire over_thr  = mag16(cur_res.data) > current_threshold_reg_ff;
  wire cnt_hit   = (conv_count_ff + 16'h0001 >= threshold_count_limit_reg_ff);
  wire thr_event = cur_res.valid && cmp_en && over_thr && (!cnt_en || cnt_hit);
  wire cnt_event = cur_res.valid && cnt_en && !cmp_en && cnt_hit;

  always_ff @(posedge core_clk) begin
    if (!rst_b || wr_config || wr_tcnt) begin
      conv_count_ff <= 16'h0000;
    end else if (cur_res.valid && (cnt_en || cmp_en)) begin
      if (cnt_hit || (cmp_en && !over_thr)) begin
        conv_count_ff <= 16'h0000;
      end else if (!cmp_en || over_thr) begin
        conv_count_ff <= conv_count_ff + 16'h0001;
      end
    end
  end

  // overrange sampling every 125 us
  wire ovr_sample = (ovr_cnt_ff == 16'(`OVR_CYCLES - 1));
  always_ff @(posedge core_clk) begin
    if (!rst_b || !ovr_en || ovr_sample) begin
      ovr_cnt_ff <= 16'h0000;
    end else begin
      ovr_cnt_ff <= ovr_cnt_ff + 16'h0001;
    end
  end

  // status flags: hardware sets win over clears
  always_comb begin
    nxt_status = converter_status_reg_ff;
    if (clr_ready) begin
      nxt_status[`ST_CUR_RDY]  = 1'b0;
      nxt_status[`ST_VOLT_RDY] = 1'b0;
      nxt_status[`ST_TEMP_RDY] = 1'b0;
    end
    if (wr_mode) begin
      nxt_status[`ST_CAL_DONE] = 1'b0;
      nxt_status[`ST_THR]      = 1'b0;
      nxt_status[`ST_CNT]      = 1'b0;
    end
    if (!cmp_en) begin
      nxt_status[`ST_THR] = 1'b0;
    end
    if (!ovr_en) begin
      nxt_status[`ST_OVR] = 1'b0;
    end else if (ovr_sample) begin
      nxt_status[`ST_OVR] = cur_overrange;
    end
    if (cur_store) begin
      nxt_status[`ST_CUR_RDY] = 1'b1;
      nxt_status[12]          = cur_res.range_err;
    end
    if (vt_store && !is_temp) begin
      nxt_status[`ST_VOLT_RDY] = 1'b1;
      nxt_status[13]           = vt_res.range_err;
    end
    if (vt_store && is_temp) begin
      nxt_status[`ST_TEMP_RDY] = 1'b1;
      nxt_status[14]           = vt_res.range_err;
    end
    if (thr_event) begin
      nxt_status[`ST_THR] = 1'b1;
    end
    if (cnt_event) begin
      nxt_status[`ST_CNT] = 1'b1;
    end
    if (cal_done) begin
      nxt_status[`ST_CAL_DONE] = 1'b1;
      nxt_status[`ST_VOLT_RDY] = 1'b1;
      nxt_status[`ST_TEMP_RDY] = 1'b1;
    end
    nxt_status[11:6] = 6'h00;
  end

  // control registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      converter_status_reg_ff      <= `RST_ZERO;
      converter_mode_reg_ff        <= `RST_ZERO;
      converter_config_reg_ff      <= 8'h00;
      converter_irq_mask_reg_ff    <= 8'h00;
      filter_rate_reg_ff           <= `RST_FILTER;
      current_threshold_reg_ff     <= `RST_ZERO;
      threshold_count_limit_reg_ff <= `RST_ZERO;
    end else begin
      converter_status_reg_ff <= nxt_status;
      if (wr_mode) converter_mode_reg_ff <= req.wdata[15:0];
      if (wr_config) converter_config_reg_ff <= req.wdata[7:0];
      if (wr_mask) converter_irq_mask_reg_ff <= req.wdata[7:0];
      if (wr_filter) filter_rate_reg_ff <= req.wdata[15:0];
      if (wr_thr) current_threshold_reg_ff <= req.wdata[15:0];
      if (wr_tcnt) threshold_count_limit_reg_ff <= req.wdata[15:0];
    end
  end

  // interrupt: only the low byte, each bit masked
  assign converter_irq = |(converter_status_reg_ff[7:0] & converter_irq_mask_reg_ff);

  // read data mux, registered; unmapped reads return zero
  logic [31:0] rd_mux;
  always_comb begin
    case (req.addr)
      `OFS_STATUS:    rd_mux = {16'h0000, converter_status_reg_ff};
      `OFS_MODE:      rd_mux = {16'h0000, converter_mode_reg_ff};
      `OFS_CONFIG:    rd_mux = {24'h000000, converter_config_reg_ff};
      `OFS_IRQ_MASK:  rd_mux = {24'h000000, converter_irq_mask_reg_ff};
      `OFS_CUR_RES:   rd_mux = {16'h0000, current_result_reg_ff};
      `OFS_VOLT_RES:  rd_mux = {16'h0000, voltage_result_reg_ff};
      `OFS_TEMP_RES:  rd_mux = {16'h0000, temp_result_reg_ff};
      `OFS_FILTER:    rd_mux = {16'h0000, filter_rate_reg_ff};
      `OFS_THRESHOLD: rd_mux = {16'h0000, current_threshold_reg_ff};
      `OFS_TCOUNT:    rd_mux = {16'h0000, threshold_count_limit_reg_ff};
      `OFS_ACCUM:     rd_mux = accum_ff;
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (req.rd) begin
      reg_rdata_ff <= rd_mux;
    end else begin
      reg_rdata_ff <= 32'h0000_0000;
    end
  end
  assign reg_rdata = reg_rdata_ff;

  // checks
  property p_irq_mask;
    @(posedge core_clk) disable iff (!rst_b)
      (converter_status_reg_ff[7:0] & converter_irq_mask_reg_ff) == 8'h00 |-> !converter_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq without masked source");

  property p_irq_high;
    @(posedge core_clk) disable iff (!rst_b)
      (converter_status_reg_ff[7:0] & converter_irq_mask_reg_ff) != 8'h00 |-> converter_irq;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("irq missing");

  property p_cur_clear;
    @(posedge core_clk) disable iff (!rst_b)
      rd_cur && !cur_store && !cal_done |=> !converter_status_reg_ff[`ST_CUR_RDY];
  endproperty
  a_cur_clear: assert property (p_cur_clear) else $error("ready not cleared");

  property p_vt_clear;
    @(posedge core_clk) disable iff (!rst_b)
      !cur_en && rd_volt && !vt_store && !cal_done && !cur_store
      |=> converter_status_reg_ff[2:0] == 3'b000;
  endproperty
  a_vt_clear: assert property (p_vt_clear) else $error("flags not cleared");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_b)
      converter_status_reg_ff[`ST_CUR_RDY] && !core_powered_down
      |=> $stable(current_result_reg_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("result overwritten");

  property p_pd_update;
    @(posedge core_clk) disable iff (!rst_b)
      core_powered_down && cur_res.valid |=> current_result_reg_ff == $past(mod_cur_data);
  endproperty
  a_pd_update: assert property (p_pd_update) else $error("no update in power down");

  property p_cal;
    @(posedge core_clk) disable iff (!rst_b)
      cal_done |=> converter_status_reg_ff[`ST_CAL_DONE] && converter_status_reg_ff[`ST_TEMP_RDY];
  endproperty
  a_cal: assert property (p_cal) else $error("calibration flags not set");

  property p_gnd;
    @(posedge core_clk) disable iff (!rst_b)
      !converter_config_reg_ff[`CFG_GND_EN] |-> !ground_switch_pin_oe && !ground_switch_res_sel;
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground switch not floating");
endmodule
`default_nettype wire

// ### bench/modulator_model.sv
// filter-result source model feeding the converter control
`timescale 1ns/1ns
`default_nettype none
module modulator_model (
  input  wire logic        core_clk,
  output logic             cur_tick,
  output logic [15:0]      cur_data,
  output logic             vt_tick,
  output logic [15:0]      vt_data
);
  initial begin
    cur_tick = 1'b0;
    vt_tick = 1'b0;
    cur_data = 16'h0000;
    vt_data = 16'h0000;
  end
  // one strobe; data is inverted after it so a stale value never looks valid
  task automatic conv(input logic vt, input logic [15:0] d, input int gap);
    @(posedge core_clk);
    if (vt) begin
      vt_tick <= 1'b1;
      vt_data <= d;
    end else begin
      cur_tick <= 1'b1;
      cur_data <= d;
    end
    @(posedge core_clk);
    vt_tick <= 1'b0;
    cur_tick <= 1'b0;
    vt_data <= ~d;
    cur_data <= ~d;
    repeat (gap) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ### bench/adc_ctl_tb.sv
// self-checking bench for the converter control
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctl_regs.svh"
module adc_ctl_tb;
  logic        core_clk, rst_b, reg_wr, reg_rd, cal_done, pd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic        conv_tick, atten, gs_o, gs_oe, gs_res, irq, ct, vt, ovr;
  logic [1:0]  mux;
  logic [15:0] cd, vd;
  int          num_errors, checks, cyc, n;

  modulator_model u_mod (.core_clk(core_clk), .cur_tick(ct), .cur_data(cd),
    .vt_tick(vt), .vt_data(vd));
  adc_ctl u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mod_cur_tick(ct), .mod_cur_data(cd), .mod_cur_err(1'b0), .mod_vt_tick(vt),
    .mod_vt_data(vd), .mod_vt_err(1'b0), .cur_overrange(ovr), .cal_done(cal_done),
    .core_powered_down(pd), .conv_tick(conv_tick), .vt_mux_sel(mux),
    .atten_buf_en(atten), .ground_switch_pin_o(gs_o), .ground_switch_pin_oe(gs_oe),
    .ground_switch_res_sel(gs_res), .converter_irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic t_reset();
    rd(`OFS_FILTER, v);
    chk("filter reset", v, 32'h0000_0007);
    rd(`OFS_STATUS, v);
    chk("status reset", v, 32'h0);
    rd(8'hfc, v);
    chk("unmapped read", v, 32'h0);
    chk("irq reset", irq, 1'b0);
  endtask
  // all four enable / resistor combinations
  task automatic t_ground();
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_CONFIG, {24'h0, i[1], 7'h00});
      wr(`OFS_MODE, {25'h0, i[0], 6'h00});
      chk("gnd oe", gs_oe, i[1]);
      chk("gnd res", gs_res, i[1] & i[0]);
      chk("gnd level", gs_o, 1'b0);
    end
  endtask
  task automatic t_vtmux();
    logic [1:0] s;
    for (int i = 0; i < 3; i++) begin
      s = (i == 2) ? 2'b11 : i[1:0];
      wr(`OFS_MODE, {22'h0, s, 8'h02});
      chk("vt mux", mux, s);
      chk("atten buf", atten, s == 2'b00);
    end
  endtask
  task automatic t_cur();
    wr(`OFS_CONFIG, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h0);
    wr(`OFS_MODE, 32'h1);
    u_mod.conv(1'b0, 16'h1111, 0);
    u_mod.conv(1'b0, 16'h2222, 0);
    rd(`OFS_STATUS, v);
    chk("cur early rdy", v[0], 1'b0);
    u_mod.conv(1'b0, 16'h8a5c, 3);
    u_mod.conv(1'b0, 16'h8a5c, 3);
    rd(`OFS_STATUS, v);
    chk("cur rdy", v[0], 1'b1);
    chk("irq masked", irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h1);
    chk("irq unmasked", irq, 1'b1);
    u_mod.conv(1'b0, 16'h0f0f, 0);
    rd(`OFS_CUR_RES, v);
    chk("cur held", v, 32'h0000_8a5c);
    rd(`OFS_STATUS, v);
    chk("rdy cleared", v[2:0], 3'b000);
    chk("irq low", irq, 1'b0);
    pd <= 1'b1;
    u_mod.conv(1'b0, 16'h1234, 0);
    u_mod.conv(1'b0, 16'h4321, 0);
    rd(`OFS_CUR_RES, v);
    chk("pd update", v, 32'h0000_4321);
    pd <= 1'b0;
  endtask
  task automatic t_vt();
    wr(`OFS_IRQ_MASK, 32'h0);
    wr(`OFS_MODE, 32'h2);
    u_mod.conv(1'b1, 16'h0101, 0);
    u_mod.conv(1'b1, 16'h0202, 0);
    rd(`OFS_STATUS, v);
    chk("vt early rdy", v[1], 1'b0);
    u_mod.conv(1'b1, 16'h7e81, 0);
    u_mod.conv(1'b1, 16'h7e81, 0);
    rd(`OFS_STATUS, v);
    chk("vt rdy", v[1], 1'b1);
    rd(`OFS_VOLT_RES, v);
    chk("vt result", v, 32'h0000_7e81);
    rd(`OFS_STATUS, v);
    chk("vt read clears", v[2:0], 3'b000);
  endtask
  task automatic t_cal();
    wr(`OFS_IRQ_MASK, 32'h0000_00f9);
    @(posedge core_clk);
    cal_done <= 1'b1;
    @(posedge core_clk);
    cal_done <= 1'b0;
    rd(`OFS_STATUS, v);
    chk("cal flag", v[15], 1'b1);
    chk("cal temp rdy", v[2], 1'b1);
    chk("upper no irq", irq, 1'b0);
    wr(`OFS_MODE, 32'h0);
    rd(`OFS_STATUS, v);
    chk("cal cleared", v[15], 1'b0);
  endtask
  // comparator, accumulator and conversion counter on settled results
  task automatic t_cmp();
    wr(`OFS_CONFIG, 32'h18);
    wr(`OFS_THRESHOLD, 32'h100);
    wr(`OFS_IRQ_MASK, 32'h10);
    wr(`OFS_ACCUM, 32'h0);
    wr(`OFS_MODE, 32'h1);
    u_mod.conv(1'b0, 16'h0001, 0);
    u_mod.conv(1'b0, 16'h0001, 0);
    u_mod.conv(1'b0, 16'hff00, 0);
    rd(`OFS_STATUS, v);
    chk("thr equal", v[4], 1'b0);
    u_mod.conv(1'b0, 16'h0102, 0);
    rd(`OFS_STATUS, v);
    chk("thr over", v[4], 1'b1);
    chk("thr irq", irq, 1'b1);
    rd(`OFS_ACCUM, v);
    chk("accum", v, 32'h0000_0002);
    wr(`OFS_CONFIG, 32'h20);
    wr(`OFS_TCOUNT, 32'h3);
    u_mod.conv(1'b0, 16'h0001, 0);
    u_mod.conv(1'b0, 16'h0001, 0);
    rd(`OFS_STATUS, v);
    chk("thr off", v[4], 1'b0);
    chk("cnt early", v[5], 1'b0);
    u_mod.conv(1'b0, 16'h0001, 0);
    rd(`OFS_STATUS, v);
    chk("cnt hit", v[5], 1'b1);
    chk("cnt masked", irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h20);
    chk("cnt irq", irq, 1'b1);
    wr(`OFS_IRQ_MASK, 32'h0);
  endtask
  // overrange flag only follows the comparator at the 125 us sample
  task automatic t_ovr();
    wr(`OFS_CONFIG, 32'h04);
    ovr <= 1'b1;
    repeat (12400) @(posedge core_clk);
    rd(`OFS_STATUS, v);
    chk("ovr early", v[3], 1'b0);
    repeat (200) @(posedge core_clk);
    rd(`OFS_STATUS, v);
    chk("ovr set", v[3], 1'b1);
    ovr <= 1'b0;
    wr(`OFS_CONFIG, 32'h0);
    rd(`OFS_STATUS, v);
    chk("ovr off", v[3], 1'b0);
  endtask
  // period between two rate strobes at the fastest setting
  task automatic t_rate();
    wr(`OFS_FILTER, 32'h0);
    wr(`OFS_MODE, 32'h1);
    n = 0;
    while (conv_tick !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (conv_tick !== 1'b1 && n < 20000);
    chk("rate period", n, 32'd12500);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    cal_done = 1'b0;
    pd = 1'b0;
    ovr = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_ground();
    t_vtmux();
    t_cur();
    t_vt();
    t_cal();
    t_cmp();
    t_ovr();
    t_rate();
    stop_test();
  end
endmodule
`default_nettype wire
